// File: iob_pkg.sv
// package for the io bus command host: states, command codes, timing counts
// assumes a single 25 MHz core clock; nothing else shared
package iob_pkg;
  localparam int unsigned CLK_HZ         = 25000000;
  localparam int unsigned XW             = 24;        // exchange width
  localparam int unsigned CMD_LSB        = 20;        // command code field
  localparam int unsigned CMD_W          = 4;
  localparam int unsigned CHAN_LSB       = 16;        // channel address field
  localparam int unsigned CHAN_W         = 4;
  localparam int unsigned OUTA_DATA_W    = 16;
  // bus timing figures in ns, nominal bus clock 4 MHz
  localparam int unsigned BUS_CLK_NS     = 250;
  localparam int unsigned CA_RC_NS       = 500;
  localparam int unsigned RC_CA_NS       = 1000;      // four bus clock periods
  localparam int unsigned CLR_NS         = 750;       // three bus clocks
  localparam int unsigned CLK_NS         = 1000000000 / CLK_HZ;
  // one bus clock = one strobe slot; least times round up
  localparam int unsigned BUS_DIV        = (BUS_CLK_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CA_RC_TICKS    = (CA_RC_NS + BUS_CLK_NS - 1) / BUS_CLK_NS;
  localparam int unsigned RC_CA_TICKS    = (RC_CA_NS + BUS_CLK_NS - 1) / BUS_CLK_NS;
  localparam int unsigned CLR_TICKS      = (CLR_NS + BUS_CLK_NS - 1) / BUS_CLK_NS;
  localparam logic [XW-1:0] XCH_RESET    = 24'h000000;

  typedef enum logic [CMD_W-1:0] {
    IOB_OUT_A     = 4'h1,
    IOB_OUT_B     = 4'h2,
    IOB_TEST      = 4'h3,
    IOB_CLR_TEST  = 4'h4,
    IOB_TEST_SR   = 4'h5,
    IOB_TERMINATE = 4'h6,
    IOB_IN        = 4'h7
  } iob_cmd_t;

  // one request from the user: command, channel, data
  typedef struct packed {
    iob_cmd_t          cmd;
    logic [CHAN_W-1:0] chan;
    logic [XW-1:0]     data;
  } iob_req_t;

  // one answer back to the user
  typedef struct packed {
    iob_cmd_t      cmd;
    logic [XW-1:0] word;
  } iob_rsp_t;

  typedef enum logic [2:0] {
    IOB_IDLE, IOB_CLEAR, IOB_PHASE_A, IOB_GAP, IOB_PHASE_B, IOB_RECOVER
  } iob_state_t;
endpackage : iob_pkg

// File: iob_fifo.sv
// synchronous valid/ready fifo, used for the answer path of the io bus host
// assumes one clock and a synchronous active-high reset
module iob_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             core_clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0]   cnt;
  } iob_fifo_st_t;

  logic [WIDTH-1:0] mem [DEPTH];
  iob_fifo_st_t st_reg;
  iob_fifo_st_t st_next;
  logic push;
  logic pop;

  assign in_ready  = (st_reg.cnt != (AW+1)'(DEPTH));
  assign out_valid = (st_reg.cnt != '0);
  assign out_data  = mem[st_reg.rd];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.wr = (st_reg.wr == AW'(DEPTH-1)) ? '0 : st_reg.wr + 1'b1;
    end
    if (pop) begin
      st_next.rd = (st_reg.rd == AW'(DEPTH-1)) ? '0 : st_reg.rd + 1'b1;
    end
    if (push && !pop) begin
      st_next.cnt = st_reg.cnt + 1'b1;
    end else if (pop && !push) begin
      st_next.cnt = st_reg.cnt - 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
    if (push) begin
      mem[st_reg.wr] <= in_data;
    end
  end
endmodule : iob_fifo

// File: iob_host.sv
// io bus command host: drives command/response strobes, clear and exchange
// assumes controls answer on the exchange in phase b while asserting send
//
// What this block does
// - command strobe high exactly one bus clock with command on exchange lines.
// - response strobe one bus clock marks phase b; take inbound word then.
// - clear pulse resets controls; host holds it at least three bus clocks.
// - exchange lines carry command, address, data or status per cycle type.
// - seven command types, each phase a then phase b.
// - host exchanges at most one 24-bit word per phase, so two per cycle.
// - transfer out a: command, channel, sixteen data bits in phase a; status back.
// - test service request issued only while service request is asserted.
// - each strobe spans exactly one bus clock trailing edge.
// - at least two bus clocks from command strobe to response strobe.
// - at least four bus clocks from response strobe to next command strobe.
// - command strobe per command write, response strobe per data access.
module iob_host #(
  parameter int unsigned FIFO_DEPTH = 8
) (
  input  wire logic               core_clk,
  input  wire logic               reset,
  // user side
  input  wire iob_pkg::iob_req_t  req,
  input  wire logic               req_valid,
  output logic                    req_ready,
  input  wire logic               clear_req,
  output iob_pkg::iob_rsp_t       rsp,
  output logic                    rsp_valid,
  input  wire logic               rsp_ready,
  output logic                    svc_pending,
  output logic                    bus_clk,
  // bus pins
  output logic                    command_active_strobe,
  output logic                    response_done_strobe,
  output logic                    io_system_clear,
  input  wire logic               service_request,
  input  wire logic               transmit_direction_select,
  input  wire logic [23:0]        data_swap_lines_in,
  output logic [23:0]             data_swap_lines_out,
  output logic                    data_swap_lines_oe
);
  localparam int unsigned RSP_W = $bits(iob_pkg::iob_rsp_t);
  localparam int unsigned DIV_W = $clog2(iob_pkg::BUS_DIV + 1);

  typedef struct packed {
    iob_pkg::iob_state_t  state;
    logic [DIV_W-1:0]     div;
    logic                 bclk;
    logic [3:0]           ticks;
    iob_pkg::iob_req_t    cur;
    logic                 ca;
    logic                 rc;
    logic                 clr;
    logic [23:0]          xout;
    logic                 xoe;
    logic                 push;
    iob_pkg::iob_rsp_t    cap;
    logic                 req_rdy;
    logic [1:0]           sr_sync;
    logic [1:0]           ios_sync;
    logic [23:0]          x_s1;
    logic [23:0]          x_s2;
  } iob_st_t;

  iob_st_t st_reg;
  iob_st_t st_next;
  logic    fifo_in_ready;
  logic    tick;
  logic    [RSP_W-1:0] fifo_out;

  // phase a word: command code, channel, up to sixteen data bits
  function automatic logic [23:0] phase_a_word(input iob_pkg::iob_req_t r);
    phase_a_word = {r.cmd, r.chan, r.data[iob_pkg::OUTA_DATA_W-1:0]};
  endfunction : phase_a_word

  function automatic logic [3:0] ticks_of(input int unsigned n);
    ticks_of = 4'(n);
  endfunction : ticks_of

  // one strobe slot ends on each rising bus clock edge
  assign tick = (st_reg.div == DIV_W'(iob_pkg::BUS_DIV - 1));

  always_comb begin
    st_next          = st_reg;
    st_next.push     = 1'b0;
    st_next.req_rdy  = 1'b0;
    st_next.sr_sync  = {st_reg.sr_sync[0], service_request};
    st_next.ios_sync = {st_reg.ios_sync[0], transmit_direction_select};
    st_next.x_s1     = data_swap_lines_in;
    st_next.x_s2     = st_reg.x_s1;
    st_next.div      = tick ? '0 : st_reg.div + 1'b1;
    st_next.bclk     = (st_next.div < DIV_W'(iob_pkg::BUS_DIV / 2));
    if (tick) begin
      if (st_reg.ticks != '0) begin
        st_next.ticks = st_reg.ticks - 1'b1;
      end
      case (st_reg.state)
        iob_pkg::IOB_IDLE: begin
          if (clear_req) begin
            st_next.state = iob_pkg::IOB_CLEAR;
            st_next.clr   = 1'b1;
            st_next.ticks = ticks_of(iob_pkg::CLR_TICKS - 1);
          end else if (req_valid && fifo_in_ready) begin
            // a service poll with no request pending is dropped unsent
            if (req.cmd == iob_pkg::IOB_TEST_SR && !st_reg.sr_sync[1]) begin
              st_next.req_rdy = 1'b1;
            end else begin
              st_next.req_rdy = 1'b1;
              st_next.cur     = req;
              st_next.state   = iob_pkg::IOB_PHASE_A;
              st_next.ca      = 1'b1;
              st_next.xout    = phase_a_word(req);
              st_next.xoe     = 1'b1;
              st_next.ticks   = ticks_of(iob_pkg::CA_RC_TICKS - 1);
            end
          end
        end
        iob_pkg::IOB_CLEAR: begin
          if (st_reg.ticks == '0) begin
            st_next.clr   = 1'b0;
            st_next.state = iob_pkg::IOB_RECOVER;
            st_next.ticks = ticks_of(iob_pkg::RC_CA_TICKS - 1);
          end
        end
        iob_pkg::IOB_PHASE_A: begin
          st_next.ca    = 1'b0;
          st_next.xoe   = 1'b0;
          st_next.state = iob_pkg::IOB_GAP;
        end
        iob_pkg::IOB_GAP: begin
          if (st_reg.ticks == '0) begin
            st_next.state = iob_pkg::IOB_PHASE_B;
            st_next.rc    = 1'b1;
            if (st_reg.cur.cmd == iob_pkg::IOB_OUT_B) begin
              st_next.xout = st_reg.cur.data;
              st_next.xoe  = 1'b1;
            end
          end
        end
        iob_pkg::IOB_PHASE_B: begin
          // inbound word taken at end of response strobe
          st_next.rc       = 1'b0;
          st_next.xoe      = 1'b0;
          st_next.push     = 1'b1;
          st_next.cap.cmd  = st_reg.cur.cmd;
          // out b answers with a zero word; poll and others keep the whole word only while control sends
          if (st_reg.cur.cmd == iob_pkg::IOB_OUT_B || !st_reg.ios_sync[1]) begin
            st_next.cap.word = iob_pkg::XCH_RESET;
          end else begin
            st_next.cap.word = st_reg.x_s2;
          end
          st_next.state = iob_pkg::IOB_RECOVER;
          st_next.ticks = ticks_of(iob_pkg::RC_CA_TICKS - 1);
        end
        iob_pkg::IOB_RECOVER: begin
          if (st_reg.ticks == '0) begin
            st_next.state = iob_pkg::IOB_IDLE;
          end
        end
        default: begin
          st_next.state = iob_pkg::IOB_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_reg       <= '0;
      st_reg.state <= iob_pkg::IOB_IDLE;
      // bus clock is high at divider zero, so no false rising edge after reset
      st_reg.bclk  <= 1'b1;
      st_reg.cap   <= '0;
      st_reg.xout  <= iob_pkg::XCH_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // answers queue here so a slow consumer stalls new commands, not the bus
  iob_fifo #(
    .WIDTH (RSP_W),
    .DEPTH (FIFO_DEPTH)
  ) u_rsp_fifo (
    .core_clk  (core_clk),
    .reset     (reset),
    .in_data   (st_reg.cap),
    .in_valid  (st_reg.push),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out),
    .out_valid (rsp_valid),
    .out_ready (rsp_ready)
  );

  assign rsp                   = iob_pkg::iob_rsp_t'(fifo_out);
  assign req_ready             = st_reg.req_rdy;
  assign svc_pending           = st_reg.sr_sync[1];
  assign bus_clk               = st_reg.bclk;
  assign command_active_strobe = st_reg.ca;
  assign response_done_strobe  = st_reg.rc;
  assign io_system_clear       = st_reg.clr;
  assign data_swap_lines_out   = st_reg.xout;
  assign data_swap_lines_oe    = st_reg.xoe;
endmodule : iob_host

// File: iob_host_checker.sv
// checker on iob_host ports: strobe slots, spacing, clear, exchange drive
// assumes a bind to iob_host, one clock, synchronous active-high reset
module iob_host_checker (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic bus_clk,
  input wire logic req_ready,
  input wire logic command_active_strobe,
  input wire logic response_done_strobe,
  input wire logic io_system_clear,
  input wire logic service_request,
  input wire logic svc_pending,
  input wire logic data_swap_lines_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  wire        ca  = command_active_strobe;
  wire        rc  = response_done_strobe;
  wire        clr = io_system_clear;
  wire        oe  = data_swap_lines_oe;
  logic [5:0] gap_reg;
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // cycles since the last response strobe, saturating
  always_ff @(posedge core_clk) begin
    if (reset) gap_reg <= 6'h3f;
    else if (rc) gap_reg <= 6'h00;
    else if (gap_reg != 6'h3f) gap_reg <= gap_reg + 6'h01;
  end
  // one slot is seven core clocks: 250 ns rounded up at 40 ns
  sequence s_ca_slot; ca [*7] ##1 !ca; endsequence
  sequence s_rc_slot; rc [*7] ##1 !rc; endsequence
  sequence s_bclk_period; bus_clk [*3] ##1 !bus_clk [*4] ##1 bus_clk; endsequence
  a_bclk_period: assert property ($rose(bus_clk) |-> s_bclk_period)
    else $error("bus clock period wrong");
  a_ca_bclk_align: assert property ($rose(ca) |-> $rose(bus_clk))
    else $error("command strobe not aligned to bus clock");
  a_ca_one_slot: assert property ($rose(ca) |-> s_ca_slot)
    else $error("command strobe not one slot");
  a_rc_one_slot: assert property ($rose(rc) |-> s_rc_slot)
    else $error("response strobe not one slot");
  a_ca_rc_gap: assert property ($rose(rc) |-> $past(ca, 14) && !$past(ca, 7))
    else $error("response strobe not two slots after command");
  a_rc_ca_gap: assert property ($rose(ca) |-> gap_reg >= 6'd28)
    else $error("command strobe too soon after response");
  a_clr_three: assert property ($fell(clr) |-> $past(clr, 21))
    else $error("clear pulse too short");
  a_clr_quiet: assert property (clr |-> !ca && !rc && !oe)
    else $error("bus active during clear");
  a_oe_in_ca: assert property (ca |-> oe)
    else $error("command word not driven");
  a_oe_release: assert property (oe |-> ca || rc)
    else $error("exchange driven outside strobes");
  a_ready_ca: assert property ($rose(ca) |-> req_ready)
    else $error("command strobe without request");
  a_sr_sync: assert property ($rose(service_request) |-> ##[1:4] svc_pending)
    else $error("service request not seen");
endmodule : iob_host_checker

// File: iob_dev_model.sv
// behavioural io control on one channel, the far side of iob_host
// assumes host strobes on core_clk; clear is taken asynchronously
module iob_dev_model #(
  parameter logic [3:0] CHAN   = 4'h3,
  parameter logic [7:0] DEV_ID = 8'h5a // arbitrary value
) (
  input  wire logic        core_clk,
  input  wire logic        ca,
  input  wire logic        rc,
  input  wire logic        clr,
  input  wire logic        need_svc,
  input  wire logic [23:0] xout,
  output logic             svc,
  output logic             send,
  output logic [23:0]      xin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [23:0] w;
  logic [23:0] ans  = 24'h000000;
  logic [23:0] ob   = 24'h000000;
  logic [7:0]  st   = 8'h00;
  logic        drv  = 1'b0;
  logic        ca_q = 1'b0;
  logic        rc_q = 1'b0;
  wire         hit  = w[19:16] == CHAN || w[23:20] == 4'h5;
  // released lines show the inverse of the last word
  assign xin  = drv ? ans : ~ans;
  assign send = drv;
  assign svc  = need_svc;
  always @(posedge core_clk or posedge clr) begin
    if (clr) begin
      st  <= 8'h00;
      drv <= 1'b0;
    end else begin
      ca_q <= ca;
      rc_q <= rc;
      if (ca) w <= xout;
      if (rc && w[23:20] == 4'h2 && w[19:16] == CHAN) ob <= xout;
      if (rc_q && !rc) drv <= 1'b0;
      // codes follow the host package numbering
      if (ca_q && !ca && hit) begin
        drv <= w[23:20] == 4'h5 ? need_svc : w[23:20] != 4'h2;
        case (w[23:20])
          4'h1: st <= w[7:0];
          4'h4: st <= 8'h00;
          default: ;
        endcase
        case (w[23:20])
          4'h1: ans <= {DEV_ID, 1'b1, 7'h00, w[7:0]};
          4'h4: ans <= {DEV_ID, 1'b1, 15'h0000};
          4'h5: ans <= 24'h000001 << CHAN;
          4'h7: ans <= {8'h00, ob[15:0]};
          default: ans <= {DEV_ID, 1'b1, 7'h00, st};
        endcase
      end
    end
  end
endmodule : iob_dev_model

// File: testbench.sv
// self-checking bench for iob_host with one device model on channel 3
// assumes the checker and device model files are compiled first
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] ID = 8'h5a; // arbitrary device id
  logic              core_clk, reset, req_valid, req_ready, clear_req, rsp_valid, rsp_ready;
  logic              svc_pending, ca, rc, clr, need_svc, svc, send, oe;
  logic              ca_q = 1'b0;
  logic [23:0]       xout, xin;
  iob_pkg::iob_req_t req;
  iob_pkg::iob_rsp_t rsp;
  int                num_errors, total_checks;
  int                ca_cnt = 0;
  bit                took;

  iob_host u_iob_host (.core_clk, .reset, .req, .req_valid, .req_ready, .clear_req, .rsp, .rsp_valid,
    .rsp_ready, .svc_pending, .bus_clk(), .command_active_strobe(ca), .response_done_strobe(rc),
    .io_system_clear(clr), .service_request(svc), .transmit_direction_select(send),
    .data_swap_lines_in(xin), .data_swap_lines_out(xout), .data_swap_lines_oe(oe));
  iob_dev_model #(.DEV_ID(ID)) u_iob_dev_model (.core_clk, .ca, .rc, .clr, .need_svc, .xout, .svc, .send, .xin);

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    ca_q <= ca;
    if (ca && !ca_q) ca_cnt <= ca_cnt + 1;
  end
  function automatic logic [23:0] st(input logic [7:0] b);
    return {ID, 1'b1, 7'h00, b};
  endfunction : st
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk) #1;
  endtask : tick
  task automatic issue(input iob_pkg::iob_cmd_t c, input logic [3:0] ch, input logic [23:0] d, input int lim);
    int n;
    n = 0;
    tick(1);
    req = '{c, ch, d};
    req_valid = 1'b1;
    do begin
      tick(1);
      n++;
    end while (req_ready !== 1'b1 && n < lim);
    took = req_ready === 1'b1;
    req_valid = 1'b0;
  endtask : issue
  task automatic get(input iob_pkg::iob_cmd_t c, input logic [23:0] w);
    int n;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 200) begin
      tick(1);
      n++;
    end
    chk("rsp_valid", 24'h1, {23'h0, rsp_valid});
    chk("rsp_cmd", {20'h0, c}, {20'h0, rsp.cmd});
    chk("rsp_word", w, rsp.word);
    rsp_ready = 1'b1;
    tick(1);
    rsp_ready = 1'b0;
    tick(1);
  endtask : get
  task automatic xfer(input iob_pkg::iob_cmd_t c, input logic [3:0] ch, input logic [23:0] d, input logic [23:0] w);
    issue(c, ch, d, 200);
    chk("taken", 24'h1, {23'h0, took});
    get(c, w);
  endtask : xfer
  task automatic t_status();
    xfer(iob_pkg::IOB_OUT_A, 4'h3, 24'h0012a5, st(8'ha5));
    xfer(iob_pkg::IOB_TEST, 4'h3, 24'h0, st(8'ha5));
    xfer(iob_pkg::IOB_TERMINATE, 4'h3, 24'h0, st(8'ha5));
    xfer(iob_pkg::IOB_OUT_A, 4'h5, 24'h0000ff, 24'h0);
    xfer(iob_pkg::IOB_TEST, 4'h3, 24'h0, st(8'ha5));
    xfer(iob_pkg::IOB_CLR_TEST, 4'h3, 24'h0, st(8'h00));
  endtask : t_status
  task automatic t_out_b_in();
    xfer(iob_pkg::IOB_OUT_B, 4'h3, 24'h7bc3d2, 24'h0);
    xfer(iob_pkg::IOB_IN, 4'h3, 24'h0, 24'h00c3d2);
  endtask : t_out_b_in
  task automatic t_service();
    int n;
    need_svc = 1'b1;
    tick(8);
    chk("svc_pending", 24'h1, {23'h0, svc_pending});
    xfer(iob_pkg::IOB_TEST_SR, 4'h0, 24'h0, 24'h000008);
    need_svc = 1'b0;
    tick(8);
    n = ca_cnt;
    issue(iob_pkg::IOB_TEST_SR, 4'h0, 24'h0, 200);
    tick(60);
    chk("refused_ca", n[23:0], ca_cnt[23:0]);
    chk("refused_rsp", 24'h0, {23'h0, rsp_valid});
  endtask : t_service
  task automatic t_clear();
    int n;
    n = 0;
    xfer(iob_pkg::IOB_OUT_A, 4'h3, 24'h000077, st(8'h77));
    clear_req = 1'b1;
    while (clr !== 1'b1 && n < 100) begin
      tick(1);
      n++;
    end
    clear_req = 1'b0;
    n = 0;
    while (clr === 1'b1 && n < 100) begin
      tick(1);
      n++;
    end
    chk("clear_len", 24'(iob_pkg::CLR_TICKS * iob_pkg::BUS_DIV), n[23:0]);
    xfer(iob_pkg::IOB_TEST, 4'h3, 24'h0, st(8'h00));
  endtask : t_clear
  task automatic t_fifo();
    for (int i = 0; i < 8; i++) begin
      issue(iob_pkg::IOB_TEST, 4'h3, 24'h0, 200);
      chk("fill", 24'h1, {23'h0, took});
    end
    issue(iob_pkg::IOB_TEST, 4'h3, 24'h0, 100);
    chk("full", 24'h0, {23'h0, took});
    for (int i = 0; i < 8; i++) get(iob_pkg::IOB_TEST, st(8'h00));
    chk("empty", 24'h0, {23'h0, rsp_valid});
  endtask : t_fifo
  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test

  initial begin
    reset = 1'b1;
    {req_valid, clear_req, rsp_ready, need_svc} = 4'h0;
    req = '0;
    {num_errors, total_checks} = {32'd0, 32'd0};
    repeat (10) @(posedge core_clk);
    #1 reset = 1'b0;
    t_status();
    t_out_b_in();
    t_service();
    t_clear();
    t_fifo();
    end_of_test();
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    end_of_test();
  end
endmodule : testbench

bind iob_host iob_host_checker u_iob_host_checker (.core_clk, .reset, .bus_clk, .req_ready, .command_active_strobe,
  .response_done_strobe, .io_system_clear, .service_request, .svc_pending, .data_swap_lines_oe);
